//--- hdl/ewd_cfg.svh
`ifndef EWD_CFG_SVH
`define EWD_CFG_SVH
// ----------------------------------------
// extension word layout
// ----------------------------------------
`define EWD_OPC_HI 15
`define EWD_OPC_LO 11
`define EWD_OPC_VAL 5'h03
`define EWD_ZC_BIT 8
`define EWD_RPT_BIT 7
`define EWD_AL_BIT 6
`define EWD_CNT_HI 3
`define EWD_CNT_LO 0
// ----------------------------------------
// addressing mode codes (as)
// ----------------------------------------
`define EWD_AM_REG 2'h0
`define EWD_AM_IDX 2'h1
`define EWD_AM_IND 2'h2
`define EWD_AM_INC 2'h3
`define EWD_PC_REG 4'h0
`define EWD_CG_REG 4'h3
// ----------------------------------------
// cycle counts
// ----------------------------------------
`define EWD_CYC_RR 4'h1
`define EWD_CYC_RPC 4'h2
`define EWD_CYC_RM 4'h4
`define EWD_CYC_IR 4'h2
`define EWD_CYC_IPC 4'h3
`define EWD_CYC_IM 4'h5
`define EWD_CYC_XR 4'h3
`define EWD_CYC_XM 4'h6
`define EWD_CYC_FAST 4'h1
`endif

//--- hdl/ewd_pkg.sv
package ewd_pkg;
    typedef enum logic [1:0] {
        EWD_LEN_RSV = 2'b00,
        EWD_LEN_20 = 2'b01,
        EWD_LEN_16 = 2'b10,
        EWD_LEN_8 = 2'b11
    } ewd_len_e;
    typedef enum logic [1:0] {
        EWD_IDLE = 2'b00,
        EWD_ARMED = 2'b01
    } ewd_state_e;
    typedef struct packed {
        ewd_state_e state;
        logic zc;
        logic rpt_reg;
        logic al;
        logic reg_form;
        logic [3:0] cnt_field;
        logic [3:0] cycles;
        logic [1:0] words;
        ewd_len_e len;
        logic ext_active;
        logic carry_zero;
        logic [3:0] rpt_count;
        logic wide;
        logic ext_seen;
    } ewd_state_s;
endpackage : ewd_pkg

//--- hdl/ewd_decoder.sv
`timescale 1ns/10ps
`include "ewd_cfg.svh"
// How it works
// - register source: 1 cycle reg, 2 to PC, 4 cycles two words to memory.
// - indirect/autoinc/immediate source: 2, 3, 5 cycles; immediate adds one word.
// - indexed/symbolic/absolute source: 3 cycles two words, or 6 cycles three words.
// - copy, bit-test, compare to memory destination finish one cycle sooner.
// - extension word when bits 15:11 fall in 1800h..1FFFh.
// - instructions after an extension word use 20-bit addresses and immediates.
// - some extended opcodes need no extension word; flagged directly.
// - register layout only for reg/reg double and reg-mode single operand.
// - zero-carry clear: carry input is current carry flag.
// - zero-carry set: carry input zero each pass; carry from final result.
// - repeat select clear: count minus one from extension bits 3:0.
// - repeat select set: bits 3:0 name a register, its low bits hold count.
// - length bit with byte/word bit: reserved, 20-bit, 16-bit, 8-bit.
module ewd_decoder
    import ewd_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic word_valid_in,
    input wire logic [15:0] word_in,
    input wire logic single_operand_form_in,
    input wire logic native_ext_in,
    input wire logic [1:0] src_mode_in,
    input wire logic [3:0] src_reg_in,
    input wire logic dst_mode_in,
    input wire logic [3:0] dst_reg_in,
    input wire logic byte_word_in,
    input wire logic copy_op_in,
    input wire logic bit_test_op_in,
    input wire logic compare_op_in,
    input wire logic carry_flag_in,
    input wire logic [3:0] rpt_reg_value_in,
    output logic ext_word_out,
    output logic [3:0] rpt_reg_sel_out,
    output logic insn_done_out,
    output logic [3:0] cycles_out,
    output logic [1:0] words_out,
    output logic [1:0] data_len_out,
    output logic wide_addr_out,
    output logic carry_in_out,
    output logic carry_zero_out,
    output logic [3:0] rpt_count_out,
    output logic reg_layout_out
);
    ewd_state_s q, d;

    function automatic logic is_ext(input logic [15:0] w);
        is_ext = (w[`EWD_OPC_HI:`EWD_OPC_LO] == `EWD_OPC_VAL);
    endfunction : is_ext

    // ----------------------------------------
    // handshake outputs
    // ----------------------------------------
    assign ext_word_out = word_valid_in && is_ext(word_in);
    // register number to read when the repeat count comes from a register
    assign rpt_reg_sel_out = q.cnt_field;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic src_is_reg, src_is_imm, src_is_ind, dst_is_mem, dst_is_pc, fast;
    logic [3:0] cyc;
    logic [1:0] wrd;
    always_comb begin
        src_is_reg = (src_mode_in == `EWD_AM_REG);
        // immediate is autoincrement on the program counter
        src_is_imm = (src_mode_in == `EWD_AM_INC) && (src_reg_in == `EWD_PC_REG);
        src_is_ind = (src_mode_in == `EWD_AM_IND) || (src_mode_in == `EWD_AM_INC);
        dst_is_mem = dst_mode_in;
        dst_is_pc = !dst_mode_in && (dst_reg_in == `EWD_PC_REG);
        fast = copy_op_in || bit_test_op_in || compare_op_in;
        cyc = `EWD_CYC_RR;
        wrd = 2'h1;
        if (src_is_reg) begin
            if (dst_is_mem) begin
                cyc = `EWD_CYC_RM;
                wrd = 2'h2;
            end else if (dst_is_pc) begin
                cyc = `EWD_CYC_RPC;
            end else begin
                cyc = `EWD_CYC_RR;
            end
        end else if (src_is_ind) begin
            if (dst_is_mem) begin
                cyc = `EWD_CYC_IM;
            end else if (dst_is_pc) begin
                cyc = `EWD_CYC_IPC;
            end else begin
                cyc = `EWD_CYC_IR;
            end
            wrd = 2'(1 + (src_is_imm ? 1 : 0) + (dst_is_mem ? 1 : 0));
        end else begin
            cyc = dst_is_mem ? `EWD_CYC_XM : `EWD_CYC_XR;
            wrd = dst_is_mem ? 2'h3 : 2'h2;
        end
        if (dst_is_mem && fast) begin
            cyc = cyc - `EWD_CYC_FAST;
        end
    end

    // ----------------------------------------
    // state update
    // ----------------------------------------
    always_comb begin
        d = q;
        d.ext_seen = 1'b0;
        case (q.state)
            EWD_IDLE: begin
                if (word_valid_in && is_ext(word_in)) begin
                    // bits 10:9 and 5:4 never sampled
                    d.zc = word_in[`EWD_ZC_BIT];
                    d.rpt_reg = word_in[`EWD_RPT_BIT];
                    d.al = word_in[`EWD_AL_BIT];
                    d.cnt_field = word_in[`EWD_CNT_HI:`EWD_CNT_LO];
                    d.ext_seen = 1'b1;
                    d.state = EWD_ARMED;
                end else if (word_valid_in) begin
                    d.cycles = cyc;
                    d.words = wrd;
                    d.ext_active = native_ext_in;
                    d.wide = native_ext_in;
                    d.len = byte_word_in ? EWD_LEN_8 : EWD_LEN_16;
                    d.carry_zero = 1'b0;
                    d.rpt_count = 4'h0;
                    d.reg_form = 1'b0;
                end
            end
            EWD_ARMED: begin
                if (word_valid_in) begin
                    d.cycles = cyc;
                    d.words = wrd;
                    d.ext_active = 1'b1;
                    d.wide = 1'b1;
                    d.len = ewd_len_e'({q.al, byte_word_in});
                    // layout choice: reg/reg or single-operand reg mode
                    // single-operand form has no destination fields to look at
                    d.reg_form = src_is_reg && (single_operand_form_in || !dst_mode_in);
                    // repeat and zero-carry meaningless outside register layout
                    d.carry_zero = d.reg_form && q.zc;
                    if (!d.reg_form) begin
                        d.rpt_count = 4'h0;
                    end else if (q.rpt_reg) begin
                        d.rpt_count = rpt_reg_value_in;
                    end else begin
                        d.rpt_count = q.cnt_field;
                    end
                    d.state = EWD_IDLE;
                end
            end
            default: d.state = EWD_IDLE;
        endcase
        if (!rst_n_in) begin
            d = '0;
            d.state = EWD_IDLE;
            d.len = EWD_LEN_16;
        end
    end

    always_ff @(posedge clock_in) begin
        q <= d;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    logic done_q;
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            done_q <= 1'b0;
        end else begin
            done_q <= word_valid_in && !is_ext(word_in);
        end
    end
    assign insn_done_out = done_q;
    assign cycles_out = q.cycles;
    assign words_out = q.words;
    assign data_len_out = q.len;
    assign wide_addr_out = q.wide;
    // carry forced to zero only for the zero-carry case
    assign carry_in_out = q.carry_zero ? 1'b0 : carry_flag_in;
    assign carry_zero_out = q.carry_zero;
    assign rpt_count_out = q.rpt_count;
    assign reg_layout_out = q.reg_form;
endmodule : ewd_decoder

//--- verification/ewd_decoder_assertions.sv
`timescale 1ns/10ps
module ewd_decoder_chk (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic word_valid_in,
    input wire logic [15:0] word_in,
    input wire logic [1:0] src_mode_in,
    input wire logic dst_mode_in,
    input wire logic [3:0] dst_reg_in,
    input wire logic byte_word_in,
    input wire logic carry_flag_in,
    input wire logic [3:0] rpt_reg_value_in,
    input wire logic ext_word_out,
    input wire logic insn_done_out,
    input wire logic [3:0] cycles_out,
    input wire logic [1:0] words_out,
    input wire logic [1:0] data_len_out,
    input wire logic wide_addr_out,
    input wire logic carry_in_out,
    input wire logic carry_zero_out,
    input wire logic [3:0] rpt_count_out
);
    // ----
    // prefix word, then the word it qualifies
    // ----
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_ext; word_valid_in && ext_word_out; endsequence
    sequence s_ins; word_valid_in && !ext_word_out; endsequence
    sequence s_rr; s_ins and (src_mode_in == 2'h0 && !dst_mode_in); endsequence
    chk_ext_detect: assert property (ext_word_out == (word_valid_in && word_in[15:11] == 5'h03))
        else $error("prefix detect wrong");
    chk_carry_pass: assert property (!carry_zero_out |-> carry_in_out == carry_flag_in)
        else $error("carry not passed");
    chk_carry_zero: assert property (carry_zero_out |-> !carry_in_out)
        else $error("carry not zeroed");
    chk_zc_latch: assert property (s_ext ##1 s_rr |=> carry_zero_out == $past(word_in[8], 2))
        else $error("zero carry latch");
    chk_rpt_count: assert property (s_ext ##1 s_rr |=> rpt_count_out ==
        ($past(word_in[7], 2) ? $past(rpt_reg_value_in) : $past(word_in[3:0], 2)))
        else $error("repeat count wrong");
    chk_len_pair: assert property (s_ext ##1 s_ins |=> wide_addr_out &&
        data_len_out == {$past(word_in[6], 2), $past(byte_word_in)}) else $error("length wrong");
    chk_done_pulse: assert property (s_ins |=> insn_done_out)
        else $error("no done pulse");
    chk_rr_cycles: assert property (s_rr and dst_reg_in != 4'h0 |=> cycles_out == 4'h1 &&
        words_out == 2'h1) else $error("reg to reg timing");
    chk_ind_pc: assert property (s_ins and (src_mode_in == 2'h2 && !dst_mode_in &&
        dst_reg_in == 4'h0) |=> cycles_out == 4'h3 && words_out == 2'h1) else $error("ind to pc");
endmodule : ewd_decoder_chk
bind ewd_decoder ewd_decoder_chk u_chk (.*);

//--- verification/ewd_mem_model.sv
`timescale 1ns/10ps
module ewd_mem_model (
    input wire logic [3:0] addr_in,
    input wire logic [3:0] reg_sel_in,
    output logic [15:0] word_out,
    output logic [3:0] reg_val_out
);
    // ----
    // program words and register low bits
    // ----
    assign reg_val_out = reg_sel_in ^ 4'h9;
    // reserved fields set in 1f7e so they must be ignored
    always_comb begin
        case (addr_in)
            4'h0: word_out = 16'h1885;
            4'h1: word_out = 16'h1f7e;
            4'h2: word_out = 16'h1800;
            4'h3: word_out = 16'h1840;
            default: word_out = {addr_in, 12'ha0b};
        endcase
    end
endmodule : ewd_mem_model

//--- verification/extension_word_decode_and_timing_test.sv
`timescale 1ns/10ps
module extension_word_decode_and_timing_test import ewd_pkg::*; ;
    logic clock_in = 1'b0, rst_n_in = 1'b0, word_valid_in = 1'b0, single_operand_form_in = 1'b0;
    logic native_ext_in = 1'b0, dst_mode_in = 1'b0, byte_word_in = 1'b0, copy_op_in = 1'b0;
    logic bit_test_op_in = 1'b0, compare_op_in = 1'b0, carry_flag_in = 1'b1;
    logic [1:0] src_mode_in = 2'h0, words_out, data_len_out;
    logic [3:0] src_reg_in = 4'h0, dst_reg_in = 4'h0, addr = 4'h4;
    logic [3:0] rpt_reg_value_in, rpt_reg_sel_out, cycles_out, rpt_count_out;
    logic [15:0] word_in;
    logic ext_word_out, insn_done_out, wide_addr_out, carry_in_out, carry_zero_out, reg_layout_out;
    int err_total = 0, num_checks = 0, cyc = 0;
    // {mode, imm, mem, pc, op, cycles, words}
    logic [15:0] tbl [14] = '{16'h0011, 16'h0821, 16'h1042, 16'h1132, 16'h8021, 16'h8831,
        16'hd052, 16'he022, 16'hf053, 16'hf343, 16'h4032, 16'h4832, 16'h5063, 16'h5253};
    ewd_decoder uut (.*);
    ewd_mem_model u_mem (.addr_in(addr), .reg_sel_in(rpt_reg_sel_out), .word_out(word_in),
        .reg_val_out(rpt_reg_value_in));
    initial begin
        forever #5 clock_in = ~clock_in;
    end
    // ----
    // shared drive and compare
    // ----
    task automatic put(input logic [3:0] a, input logic [15:0] m, input logic b);
        @(posedge clock_in);
        addr <= a;
        word_valid_in <= 1'b1;
        src_mode_in <= m[15:14];
        src_reg_in <= m[13] ? 4'h0 : 4'h5;
        dst_mode_in <= m[12];
        dst_reg_in <= m[11] ? 4'h0 : 4'h6;
        copy_op_in <= m[9:8] == 2'h1;
        compare_op_in <= m[9:8] == 2'h2;
        bit_test_op_in <= m[9:8] == 2'h3;
        byte_word_in <= b;
    endtask : put
    task fin;
        @(posedge clock_in);
        word_valid_in <= 1'b0;
        #1;
    endtask : fin
    task chk(input string n, input logic [3:0] e, input logic [3:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task complete_run;
        if (err_total == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : complete_run
    // ----
    // scenarios
    // ----
    task t_timing;
        foreach (tbl[i]) begin
            put(4'h4, tbl[i], 1'b0);
            fin;
            chk("cycles", tbl[i][7:4], cycles_out);
            chk("words", tbl[i][3:0], {2'h0, words_out});
            chk("plain_len", 4'h2, {2'h0, data_len_out});
            chk("done", 4'h1, {3'h0, insn_done_out});
        end
    endtask : t_timing
    task t_ext(input logic [3:0] a, input logic [3:0] cnt, input logic zc, input logic [1:0] len);
        put(a, 16'h0011, 1'b1);
        #1;
        chk("ext_word", 4'h1, {3'h0, ext_word_out});
        put(4'h4, 16'h0011, 1'b1);
        fin;
        chk("rpt_sel", a[0] ? 4'he : 4'h5, rpt_reg_sel_out);
        chk("rpt_count", cnt, rpt_count_out);
        chk("carry_zero", {3'h0, zc}, {3'h0, carry_zero_out});
        chk("carry_in", {3'h0, !zc}, {3'h0, carry_in_out});
        chk("len", {2'h0, len}, {2'h0, data_len_out});
        chk("wide", 4'h1, {3'h0, wide_addr_out});
    endtask : t_ext
    task t_len_layout;
        for (int k = 0; k < 4; k++) begin
            put(4'h2 + k[3:0] / 4'h2, 16'h0011, 1'b0);
            put(4'h4, k[0] ? 16'h0011 : 16'h4032, k[0]);
            fin;
            chk("len_pair", k[3:0], {2'h0, data_len_out});
            chk("layout", {3'h0, k[0]}, {3'h0, reg_layout_out});
        end
        put(4'h4, 16'h1042, 1'b0);
        native_ext_in <= 1'b1;
        fin;
        chk("native", 4'h1, {3'h0, wide_addr_out});
        put(4'h2, 16'h0011, 1'b0);
        put(4'h4, 16'h1042, 1'b0);
        single_operand_form_in <= 1'b1;
        fin;
        chk("single_layout", 4'h1, {3'h0, reg_layout_out});
    endtask : t_len_layout
    initial begin
        repeat (10) @(posedge clock_in);
        rst_n_in <= 1'b1;
        t_timing;
        t_ext(4'h1, 4'he, 1'b1, 2'h3);
        t_ext(4'h0, 4'hc, 1'b0, 2'h1);
        t_len_layout;
        complete_run;
    end
    // budget well above the roughly 60 cycles the scenarios need
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            complete_run;
        end
    end
endmodule : extension_word_decode_and_timing_test
